// ---- core/fault_pkg.sv ----
// Shared constants and carrier types for the LED driver fault supervisor.
`default_nettype none
package fault_pkg;
  // ---------------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 5;
  localparam int RETRY_TIME_US   = 1000;
  localparam int QUALIFY_TIME_US = 10000;
  localparam int DEGLITCH_TIME_NS = 25000;
  localparam int ONTIME_MAX_NS    = 20000;
  localparam int TICK_TIME_NS     = 1000;
  localparam int TICK_CYCLES      = TICK_TIME_NS / CLOCK_PERIOD_NS;
  localparam int RETRY_TICKS      = RETRY_TIME_US * 1000 / TICK_TIME_NS;
  localparam int QUALIFY_TICKS    = QUALIFY_TIME_US * 1000 / TICK_TIME_NS;
  localparam int DEGLITCH_TICKS   = (DEGLITCH_TIME_NS + TICK_TIME_NS - 1) / TICK_TIME_NS;
  localparam int ONTIME_MAX_CYCLES = ONTIME_MAX_NS / CLOCK_PERIOD_NS;
  localparam int PWM_CYCLES       = 128;
  localparam int OVERCURRENT_REPORT_COUNT = 2;

  // ---------------------------------------------------------------------
  // Detector indications from the power stage
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic overcurrent_trip;
    logic feedback_over_high;
    logic feedback_below_low;
    logic feedback_below_open;
    logic output_below_short;
    logic boot_drop_high;
    logic boot_undervoltage_lockout;
    logic temp_over_shutdown;
    logic temp_below_restart;
  } detect_type;

  typedef enum logic [1:0] {
    THERMAL_RUN  = 2'b00,
    THERMAL_SHUT = 2'b01
  } thermal_state_type;
endpackage
`default_nettype wire

// ---- core/fault_timer.sv ----
// Qualify/recover timer for one fault class, counted on timebase ticks.
`default_nettype none
module fault_timer #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  done
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;

  always_comb begin
    count_d = count_q;
    if (!run) begin
      count_d = '0;
    end else if (tick && count_q != limit) begin
      count_d = count_q + WIDTH'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign done = run && (count_q == limit);
endmodule
`default_nettype wire

// ---- core/led_fault_supervisor.sv ----
// Fault supervisor: gates the high-side switch and drives the fault line.
//
// What this block does
// - Over 165C: stop switching, report fault.
// - Restart below 140C, release fault at once.
// - Fault line is open drain, pulls low.
// - Overcurrent: switch off, retry 1ms, report second.
// - Overcurrent report released after 10ms clean.
// - Feedback over 2V: off, report now, retry.
// - Recover below 1.55V; release 10ms later.
// - Undimmed open string: low feedback 10ms.
// - Dimmed open string: deglitch, 128 cycles, ontime.
// - Open string release after 10ms good.
// - Short string: output below 1V, qualified.
// - Short string release after 10ms above.
// - Open bootstrap: off, report now, 10ms release.
// - Bootstrap lockout: off, qualified report, 10ms release.
// - Long ontime or overcurrent: off, retry, report.
// - Ontime fault released after 10ms clean.
// - Shorted ontime resistor, enable short: no report.
// - Each overcurrent trip: hiccup off, restart.
`default_nettype none
module led_fault_supervisor #(
  parameter int RETRY_TICKS   = fault_pkg::RETRY_TICKS,
  parameter int QUALIFY_TICKS = fault_pkg::QUALIFY_TICKS,
  parameter int TICK_CYCLES   = fault_pkg::TICK_CYCLES,
  parameter int PWM_CYCLES    = fault_pkg::PWM_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire fault_pkg::detect_type detect,
  input  wire logic                  enable_pwm,
  input  wire logic                  dimming_mode,
  input  wire logic                  switch_request,
  input  wire logic                  fault_report_n_in,
  output logic                       fault_report_n_out,
  output logic                       fault_report_n_oe,
  output logic                       switch_on,
  output logic                       output_enable
);
  // -------------------------------------------------------------------
  // Timebase
  // -------------------------------------------------------------------
  logic [15:0] tick_count_q;
  logic [15:0] tick_count_d;
  logic        tick;

  always_comb begin
    tick_count_d = tick_count_q + 16'h0001;
    if (tick_count_q == 16'(TICK_CYCLES - 1)) begin
      tick_count_d = 16'h0000;
    end
  end
  assign tick = (tick_count_q == 16'(TICK_CYCLES - 1));

  // -------------------------------------------------------------------
  // Thermal shutdown with hysteresis
  // -------------------------------------------------------------------
  fault_pkg::thermal_state_type thermal_q;
  fault_pkg::thermal_state_type thermal_d;

  always_comb begin
    thermal_d = thermal_q;
    case (thermal_q)
      fault_pkg::THERMAL_RUN: begin
        if (detect.temp_over_shutdown) begin
          thermal_d = fault_pkg::THERMAL_SHUT;
        end
      end
      fault_pkg::THERMAL_SHUT: begin
        if (detect.temp_below_restart) begin
          thermal_d = fault_pkg::THERMAL_RUN;
        end
      end
      default: thermal_d = fault_pkg::THERMAL_RUN;
    endcase
  end

  // -------------------------------------------------------------------
  // Dimming edge counter and on-time watchdog
  // -------------------------------------------------------------------
  logic        pwm_prev_q;
  logic        pwm_prev_d;
  logic        pwm_rise;
  logic [11:0] ontime_q;
  logic [11:0] ontime_d;
  logic        ontime_over;

  // The enable input rests high, so the edge memory resets high as well;
  // a low reset value would count a false dimming edge after reset.
  assign pwm_rise = enable_pwm && !pwm_prev_q;
  assign ontime_over = (ontime_q == 12'(fault_pkg::ONTIME_MAX_CYCLES));

  always_comb begin
    pwm_prev_d = enable_pwm;
    ontime_d   = 12'h000;
    if (switch_on && ontime_q != 12'(fault_pkg::ONTIME_MAX_CYCLES)) begin
      ontime_d = ontime_q + 12'h001;
    end else if (switch_on) begin
      ontime_d = ontime_q;
    end
  end

  // -------------------------------------------------------------------
  // Overcurrent class: hiccup retry and trip counting
  // -------------------------------------------------------------------
  logic        oc_event;
  logic        hiccup_q;
  logic        hiccup_d;
  logic [15:0] hiccup_count_q;
  logic [15:0] hiccup_count_d;
  logic [1:0]  oc_trips_q;
  logic [1:0]  oc_trips_d;
  logic        oc_report_q;
  logic        oc_report_d;
  logic        oc_clean_done;

  // Shorted inductor, shorted set resistor, output to ground and open
  // ontime resistor all share this path.
  assign oc_event = (detect.overcurrent_trip && switch_on) || ontime_over;

  always_comb begin
    hiccup_d       = hiccup_q;
    hiccup_count_d = hiccup_count_q;
    oc_trips_d     = oc_trips_q;
    oc_report_d    = oc_report_q;
    if (oc_event) begin
      hiccup_d       = 1'b1;
      hiccup_count_d = 16'h0000;
      if (oc_trips_q != 2'(fault_pkg::OVERCURRENT_REPORT_COUNT)) begin
        oc_trips_d = oc_trips_q + 2'b01;
      end
      if (oc_trips_q == 2'(fault_pkg::OVERCURRENT_REPORT_COUNT - 1) || ontime_over) begin
        oc_report_d = 1'b1;
      end
    end else begin
      if (hiccup_q && tick) begin
        hiccup_count_d = hiccup_count_q + 16'h0001;
        if (hiccup_count_q == 16'(RETRY_TICKS - 1)) begin
          hiccup_d = 1'b0;
        end
      end
      if (oc_clean_done) begin
        oc_trips_d  = 2'b00;
        oc_report_d = 1'b0;
      end
    end
  end

  fault_timer u_oc_clean (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick),
    .run   (!oc_event && oc_trips_q != 2'b00),
    .limit (16'(QUALIFY_TICKS)),
    .done  (oc_clean_done)
  );

  // -------------------------------------------------------------------
  // Open set resistor and open bootstrap: immediate report
  // -------------------------------------------------------------------
  logic iset_open_q;
  logic iset_open_d;
  logic iset_clean_done;
  logic boot_open_q;
  logic boot_open_d;
  logic boot_clean_done;

  always_comb begin
    iset_open_d = iset_open_q;
    boot_open_d = boot_open_q;
    if (detect.feedback_over_high) begin
      iset_open_d = 1'b1;
    end else if (iset_clean_done) begin
      iset_open_d = 1'b0;
    end
    if (detect.boot_drop_high && switch_on) begin
      boot_open_d = 1'b1;
    end else if (boot_clean_done) begin
      boot_open_d = 1'b0;
    end
  end

  fault_timer u_iset_clean (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick),
    .run   (iset_open_q && detect.feedback_below_low),
    .limit (16'(QUALIFY_TICKS)),
    .done  (iset_clean_done)
  );

  fault_timer u_boot_clean (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (tick),
    .run   (boot_open_q && !detect.boot_drop_high),
    .limit (16'(QUALIFY_TICKS)),
    .done  (boot_clean_done)
  );

  // -------------------------------------------------------------------
  // Qualified faults: open string, short string, bootstrap lockout
  // -------------------------------------------------------------------
  localparam int QUALIFIED = 3;
  logic [QUALIFIED-1:0] q_cond;
  logic [QUALIFIED-1:0] q_latched_q;
  logic [QUALIFIED-1:0] q_latched_d;
  logic [QUALIFIED-1:0] q_undimmed_done;
  logic [QUALIFIED-1:0] q_deglitch_done;
  logic [QUALIFIED-1:0] q_recover_done;
  logic [QUALIFIED-1:0] q_dimmed_hit;
  logic [7:0]           q_pwm_q [QUALIFIED];
  logic [7:0]           q_pwm_d [QUALIFIED];

  assign q_cond[0] = detect.feedback_below_open;
  assign q_cond[1] = detect.output_below_short;
  assign q_cond[2] = detect.boot_undervoltage_lockout;

  genvar g;
  generate
    for (g = 0; g < QUALIFIED; g++) begin : g_qual
      fault_timer u_undimmed (
        .clock (clock),
        .rst_n (rst_n),
        .tick  (tick),
        .run   (q_cond[g] && !dimming_mode && !q_latched_q[g]),
        .limit (16'(QUALIFY_TICKS)),
        .done  (q_undimmed_done[g])
      );
      fault_timer u_deglitch (
        .clock (clock),
        .rst_n (rst_n),
        .tick  (tick),
        .run   (q_cond[g] && dimming_mode && !q_latched_q[g]),
        .limit (16'(fault_pkg::DEGLITCH_TICKS)),
        .done  (q_deglitch_done[g])
      );
      fault_timer u_recover (
        .clock (clock),
        .rst_n (rst_n),
        .tick  (tick),
        .run   (q_latched_q[g] && !q_cond[g]),
        .limit (16'(QUALIFY_TICKS)),
        .done  (q_recover_done[g])
      );

      // The lockout channel needs no deglitch; its comparator is already
      // a latched lockout, so its condition counts cycles directly.
      assign q_dimmed_hit[g] = (g == 2) ? q_cond[g] : q_deglitch_done[g];

      always_comb begin
        q_pwm_d[g]     = q_pwm_q[g];
        q_latched_d[g] = q_latched_q[g];
        if (!q_dimmed_hit[g] || !dimming_mode) begin
          q_pwm_d[g] = 8'h00;
        end else if (pwm_rise && q_pwm_q[g] != 8'(PWM_CYCLES)) begin
          q_pwm_d[g] = q_pwm_q[g] + 8'h01;
        end
        if (!q_latched_q[g]) begin
          if (q_undimmed_done[g] || (q_pwm_q[g] == 8'(PWM_CYCLES))) begin
            q_latched_d[g] = 1'b1;
          end else if (g == 0 && dimming_mode && q_cond[g] && ontime_over) begin
            q_latched_d[g] = 1'b1;
          end
        end else if (q_recover_done[g]) begin
          q_latched_d[g] = 1'b0;
        end
      end

      always_ff @(posedge clock) begin
        if (!rst_n) begin
          q_pwm_q[g]     <= 8'h00;
          q_latched_q[g] <= 1'b0;
        end else begin
          q_pwm_q[g]     <= q_pwm_d[g];
          q_latched_q[g] <= q_latched_d[g];
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------
  // Switch gating and fault line
  // -------------------------------------------------------------------
  logic report_d;
  logic report_q;
  logic thermal_shut;

  assign thermal_shut = (thermal_q == fault_pkg::THERMAL_SHUT);

  // The enable input shorted to the set resistor just reads as a low
  // enable: output stays off and nothing is reported.
  always_comb begin
    report_d = (thermal_d == fault_pkg::THERMAL_SHUT)
               || oc_report_d || iset_open_d || boot_open_d
               || (|q_latched_d);
  end

  // A trip drops the switch at the next edge through the hiccup register.
  // Gating the switch with the trip itself would hide every trip from oc_event.
  assign switch_on = output_enable && switch_request
                     && !hiccup_q
                     && !detect.feedback_over_high
                     && !(detect.boot_drop_high && boot_open_q)
                     && !detect.boot_undervoltage_lockout;

  assign output_enable = enable_pwm && !thermal_shut
                         && !iset_open_q && !(|q_latched_q[1:0]);

  // Open drain: drive low only while reporting, enable is low-active.
  assign fault_report_n_out = 1'b0;
  assign fault_report_n_oe  = !report_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_count_q   <= 16'h0000;
      thermal_q      <= fault_pkg::THERMAL_RUN;
      pwm_prev_q     <= 1'b1;
      ontime_q       <= 12'h000;
      hiccup_q       <= 1'b0;
      hiccup_count_q <= 16'h0000;
      oc_trips_q     <= 2'b00;
      oc_report_q    <= 1'b0;
      iset_open_q    <= 1'b0;
      boot_open_q    <= 1'b0;
      report_q       <= 1'b0;
    end else begin
      tick_count_q   <= tick_count_d;
      thermal_q      <= thermal_d;
      pwm_prev_q     <= pwm_prev_d;
      ontime_q       <= ontime_d;
      hiccup_q       <= hiccup_d;
      hiccup_count_q <= hiccup_count_d;
      oc_trips_q     <= oc_trips_d;
      oc_report_q    <= oc_report_d;
      iset_open_q    <= iset_open_d;
      boot_open_q    <= boot_open_d;
      report_q       <= report_d;
    end
  end
endmodule
`default_nettype wire

// ---- verification/fault_host_model.sv ----
// Host side of the fault line: pull-up and the level the host reads.
`default_nettype none
module fault_host_model (
  input  wire logic fault_report_n_out,
  input  wire logic fault_report_n_oe,
  output logic      fault_line,
  output logic      fault_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // A released line shows the pull-up, never the last driven value.
  assign fault_line = fault_report_n_oe ? 1'b1 : fault_report_n_out;
  assign fault_seen = !fault_line;
endmodule
`default_nettype wire

// ---- verification/led_fault_supervisor_props.sv ----
// Concurrent checks on the fault supervisor ports.
`default_nettype none
module led_fault_supervisor_props #(
  parameter int RETRY_TICKS   = 5,
  parameter int QUALIFY_TICKS = 20,
  parameter int TICK_CYCLES   = 4,
  parameter int PWM_CYCLES    = 4
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire fault_pkg::detect_type detect,
  input  wire logic                  enable_pwm,
  input  wire logic                  dimming_mode,
  input  wire logic                  switch_request,
  input  wire logic                  fault_report_n_in,
  input  wire logic                  fault_report_n_out,
  input  wire logic                  fault_report_n_oe,
  input  wire logic                  switch_on,
  input  wire logic                  output_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Cycles since the last immediate-class cause; it saturates so reset reads as long clean.
  logic [31:0] clean_q;
  logic [31:0] clean_d;
  always_comb begin
    clean_d = clean_q;
    if (detect.feedback_over_high || (detect.boot_drop_high && switch_on)) begin
      clean_d = '0;
    end else if (clean_q != 32'hFFFFFFFF) begin
      clean_d = clean_q + 32'h00000001;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clean_q <= 32'hFFFFFFFF;
    end else begin
      clean_q <= clean_d;
    end
  end

  sequence s_trip;
    detect.overcurrent_trip && switch_on;
  endsequence
  sequence s_hiccup;
    !switch_on [*4];
  endsequence

  property p_pin_low;
    fault_report_n_out == 1'b0;
  endproperty
  property p_hot_report;
    detect.temp_over_shutdown |=> !fault_report_n_oe;
  endproperty
  property p_hot_off;
    detect.temp_over_shutdown |=> !switch_on && !output_enable;
  endproperty
  property p_fb_high;
    detect.feedback_over_high |=> !fault_report_n_oe && !switch_on;
  endproperty
  property p_boot_open;
    detect.boot_drop_high && switch_on |=> !fault_report_n_oe;
  endproperty
  property p_hiccup;
    s_trip |=> s_hiccup;
  endproperty
  property p_gate;
    switch_on |-> switch_request;
  endproperty
  property p_release;
    $rose(fault_report_n_oe) |-> clean_q >= 32'((QUALIFY_TICKS - 1) * TICK_CYCLES);
  endproperty
  property p_lockout_off;
    detect.boot_undervoltage_lockout |-> !switch_on;
  endproperty

  a_pin_low: assert property (p_pin_low)
    else $error("fault pin drive level is not low");
  a_hot_report: assert property (p_hot_report)
    else $error("overheat not reported next cycle");
  a_hot_off: assert property (p_hot_off)
    else $error("overheat left the switch or output on");
  a_fb_high: assert property (p_fb_high)
    else $error("high feedback not reported with switch off");
  a_boot_open: assert property (p_boot_open)
    else $error("bootstrap drop not reported next cycle");
  a_hiccup: assert property (p_hiccup)
    else $error("switch restarted too soon after a trip");
  a_gate: assert property (p_gate)
    else $error("switch on without a request");
  a_release: assert property (p_release)
    else $error("fault line released before the clean window");
  a_lockout_off: assert property (p_lockout_off)
    else $error("switch on during bootstrap lockout");
endmodule

bind led_fault_supervisor led_fault_supervisor_props #(
  .RETRY_TICKS(RETRY_TICKS), .QUALIFY_TICKS(QUALIFY_TICKS),
  .TICK_CYCLES(TICK_CYCLES), .PWM_CYCLES(PWM_CYCLES)
) props (
  .clock(clock), .rst_n(rst_n), .detect(detect), .enable_pwm(enable_pwm),
  .dimming_mode(dimming_mode), .switch_request(switch_request),
  .fault_report_n_in(fault_report_n_in), .fault_report_n_out(fault_report_n_out),
  .fault_report_n_oe(fault_report_n_oe), .switch_on(switch_on),
  .output_enable(output_enable)
);
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the fault supervisor.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TC = 4;
  localparam int QC = 20 * TC;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  fault_pkg::detect_type detect = '0;
  logic                  enable_pwm = 1'b1;
  logic                  dimming_mode = 1'b0;
  logic                  switch_request = 1'b0;
  logic                  dim_run = 1'b0;
  logic                  last_line = 1'b1;
  logic                  fault_line, fault_seen, drive_lvl, drive_oe, switch_on, output_enable;
  logic                  exp_q[$];
  int                    errors = 0;
  int                    checked = 0;
  integer                seed = 32'h72c1;
  int                    qual[3] = '{5, 4, 2};

  always #2.5 clock = ~clock;

  led_fault_supervisor #(.RETRY_TICKS(5), .QUALIFY_TICKS(20), .TICK_CYCLES(TC),
    .PWM_CYCLES(4)) dut (
    .clock(clock), .rst_n(rst_n), .detect(detect), .enable_pwm(enable_pwm),
    .dimming_mode(dimming_mode), .switch_request(switch_request),
    .fault_report_n_in(fault_line), .fault_report_n_out(drive_lvl),
    .fault_report_n_oe(drive_oe), .switch_on(switch_on), .output_enable(output_enable));
  fault_host_model host (.fault_report_n_out(drive_lvl), .fault_report_n_oe(drive_oe),
    .fault_line(fault_line), .fault_seen(fault_seen));

  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Notes the level expected next, then waits for it within a cycle window.
  task automatic expect_line(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    exp_q.push_back(lvl);
    while (fault_line !== lvl && n <= hi) begin
      cyc(1);
      n++;
    end
    check(n >= lo && n <= hi, 1'b1);
    if (n > hi) final_report();
  endtask

  // Dimming pulses of random width; the input rests high when dimming is off.
  always begin
    cyc(4 + $unsigned($random(seed)) % 5);
    enable_pwm = !(dim_run && enable_pwm);
  end

  // Any change of the line is matched against the oldest note.
  always @(posedge clock) begin
    if (rst_n && fault_line !== last_line) begin
      if (exp_q.size() == 0) check(fault_line, last_line);
      else check(fault_line, exp_q.pop_front());
    end
    last_line <= fault_line;
  end

  initial begin
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    detect.temp_over_shutdown = 1'b1;
    expect_line(1'b0, 1, 2);
    check(output_enable, 1'b0);
    check(fault_seen, 1'b1);
    cyc(3);
    detect.temp_over_shutdown = 1'b0;
    detect.temp_below_restart = 1'b1;
    expect_line(1'b1, 1, 2);
    detect.temp_below_restart = 1'b0;
    switch_request = 1'b1;
    cyc(2);
    detect.overcurrent_trip = 1'b1;
    cyc(1);
    detect.overcurrent_trip = 1'b0;
    cyc(5 * TC + 2 * TC);
    check(switch_on, 1'b1);
    detect.overcurrent_trip = 1'b1;
    expect_line(1'b0, 1, 2);
    detect.overcurrent_trip = 1'b0;
    expect_line(1'b1, QC - 2 * TC, QC + 2 * TC);
    cyc(2);
    detect.feedback_over_high = 1'b1;
    expect_line(1'b0, 1, 2);
    detect.feedback_over_high = 1'b0;
    detect.feedback_below_low = 1'b1;
    expect_line(1'b1, QC - 2 * TC, QC + 2 * TC);
    detect.feedback_below_low = 1'b0;
    cyc(2);
    detect.boot_drop_high = 1'b1;
    expect_line(1'b0, 1, 2);
    detect.boot_drop_high = 1'b0;
    switch_request = 1'b0;
    expect_line(1'b1, QC - 2 * TC, QC + 2 * TC);
    foreach (qual[i]) begin
      detect[qual[i]] = 1'b1;
      expect_line(1'b0, QC - 2 * TC, QC + 2 * TC);
      detect[qual[i]] = 1'b0;
      expect_line(1'b1, QC - 2 * TC, QC + 2 * TC);
    end
    dimming_mode = 1'b1;
    dim_run = 1'b1;
    for (int i = 0; i < 3; i++) begin
      detect[qual[i]] = 1'b1;
      expect_line(1'b0, (i == 2) ? 24 : 24 * TC, 300);
      detect[qual[i]] = 1'b0;
      expect_line(1'b1, QC - 2 * TC, QC + 2 * TC);
    end
    dim_run = 1'b0;
    dimming_mode = 1'b0;
    cyc(20);
    switch_request = 1'b1;
    expect_line(1'b0, 3995, 4005);
    switch_request = 1'b0;
    expect_line(1'b1, QC - 2 * TC, QC + 2 * TC);
    cyc(10);
    final_report();
  end
endmodule
`default_nettype wire
